// *** rtl/aes_axis.sv ***
`timescale 1ns/100ps
// Function
// - Amplifier enable drops on watchdog, motor-off command, or error trip.
// - Amplifier enable is active high by default.
// - Channels A and B decode into a position count; index optional.
// - Pulse/direction mode: pulses on A, direction from B.
// - In quadrature mode, one toggling channel only dithers the count by one.
// - Error reaching the limit with off-on-error disables the amplifier.
// - Motor command magnitude clamped to torque limit, default 9.99 V.
// - Software inverts loop polarity and encoder direction.
// - Relative move and begin motion target current position plus distance.
// - Stepper axis generates no error and no servo action.
module aes_axis
  import aes_pkg::*;
#(
  parameter int SERVO_CYC  = SERVO_CYCLES,  // Servo period in clocks
  parameter int WDOG_CYC   = WDOG_CYCLES,   // Watchdog timeout in clocks
  parameter int STEP_COUNT = 16             // Profile counts per servo cycle
) (
  input  wire logic        clk,                  // System clock
  input  wire logic        rstn,                 // Async reset, active low
  input  wire logic        psel,                 // APB select
  input  wire logic        penable,              // APB enable
  input  wire logic        pwrite,               // APB direction
  input  wire logic [7:0]  paddr,                // APB byte address
  input  wire logic [31:0] pwdata,               // APB write data
  output logic             pready,               // APB ready
  output logic [31:0]      prdata,               // APB read data
  output logic             pslverr,              // APB error
  input  wire logic        enc_chan_a,           // Encoder channel A
  input  wire logic        enc_chan_b,           // Encoder channel B
  input  wire logic        enc_index,            // Encoder index
  output logic             amp_enable_out,       // Amplifier enable
  output logic [15:0]      analog_motor_command, // Signed DAC code
  output logic             irq                   // Interrupt level
);
  logic [CTL_W-1:0] ctrl_q;
  logic [31:0]      error_limit_q;
  logic [15:0]      torque_clamp_q;
  logic [31:0]      relative_distance_q;
  logic [31:0]      tell_position_q;
  logic [31:0]      cmd_pos_q;
  logic [31:0]      target_q;
  logic [31:0]      err_q;
  logic [ST_W-1:0]  status_q;
  logic [ST_W-1:0]  mask_q;
  logic             amp_on_q;
  logic             moving_q;
  logic [31:0]      servo_cnt_q;
  logic [31:0]      wdog_cnt_q;
  logic             servo_tick;
  logic             wdog_fire;
  logic             wr_done;
  logic             rd_done;
  logic             motor_off_cmd;
  logic             motor_on_cmd;
  logic             begin_motion;
  logic             wdog_kick;
  logic             step_up;
  logic             step_dn;
  logic             index_seen;
  logic [31:0]      err_d;
  logic [31:0]      err_abs;
  logic             err_trip;
  logic             stepper;
  logic [31:0]      drive;
  logic [31:0]      clamp_pos;
  logic [31:0]      clamp_neg;
  logic [31:0]      diff;
  logic [ST_W-1:0]  events;
  logic [31:0]      rd_mux;
  logic             rd_hit;

  assign stepper = ctrl_q[CTL_STEPPER];

  // Encoder front end
  aes_enc_decode u_enc (
    .clk       (clk),
    .rstn      (rstn),
    .a_pin     (enc_chan_a),
    .b_pin     (enc_chan_b),
    .idx_pin   (enc_index),
    .pulse_dir (ctrl_q[CTL_PULSE_DIR]),
    .dir_inv   (ctrl_q[CTL_ENC_INV]),
    .step_up_q (step_up),
    .step_dn_q (step_dn),
    .index_q   (index_seen)
  );

  // APB handshake: no wait state, answer registered in setup
  assign wr_done = pready & psel & penable & pwrite & ~pslverr;
  assign rd_done = pready & psel & penable & ~pwrite;

  always_comb begin
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      OFS_CTRL:   rd_mux = {{(32-CTL_W){1'b0}}, ctrl_q};
      OFS_CMD:    rd_mux = 32'h0000_0000;
      OFS_ERRLIM: rd_mux = error_limit_q;
      OFS_TORQUE: rd_mux = {16'h0000, torque_clamp_q};
      OFS_RELDST: rd_mux = relative_distance_q;
      OFS_TELLPS: rd_mux = tell_position_q;
      OFS_CMDPOS: rd_mux = cmd_pos_q;
      OFS_POSERR: rd_mux = err_q;
      OFS_STATUS: rd_mux = {{(32-ST_W){1'b0}}, status_q};
      OFS_MASK:   rd_mux = {{(32-ST_W){1'b0}}, mask_q};
      default:    rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
      pslverr <= psel & ~penable & ~rd_hit;
    end
  end

  // Command strobes
  assign motor_off_cmd = wr_done && paddr == OFS_CMD && pwdata[CMD_MOTOR_OFF];
  assign motor_on_cmd  = wr_done && paddr == OFS_CMD && pwdata[CMD_MOTOR_ON];
  assign begin_motion  = wr_done && paddr == OFS_CMD && pwdata[CMD_BEGIN];
  assign wdog_kick     = wr_done && paddr == OFS_CMD && pwdata[CMD_WDOG_KICK];

  // Software registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q              <= '0;
      error_limit_q       <= ERRLIM_RST;
      torque_clamp_q      <= TORQUE_RST;
      relative_distance_q <= 32'h0000_0000;
      mask_q              <= '0;
    end else if (wr_done) begin
      unique case (paddr)
        OFS_CTRL:   ctrl_q <= pwdata[CTL_W-1:0];
        OFS_ERRLIM: error_limit_q <= pwdata;
        // Clamp above full scale would wrap the negative bound
        OFS_TORQUE: torque_clamp_q <= (pwdata[15:0] > TORQUE_MAX)
                                      ? TORQUE_MAX : pwdata[15:0];
        OFS_RELDST: relative_distance_q <= pwdata;
        OFS_MASK:   mask_q <= pwdata[ST_W-1:0];
        default:    ;
      endcase
    end
  end

  // Servo rate enable
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      servo_cnt_q <= 32'h0000_0000;
    end else if (servo_cnt_q == 32'(SERVO_CYC - 1)) begin
      servo_cnt_q <= 32'h0000_0000;
    end else begin
      servo_cnt_q <= servo_cnt_q + 32'h0000_0001;
    end
  end
  assign servo_tick = servo_cnt_q == 32'(SERVO_CYC - 1);

  // Watchdog: software must kick within the timeout while enabled
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wdog_cnt_q <= 32'h0000_0000;
    end else if (wdog_kick || !amp_on_q) begin
      wdog_cnt_q <= 32'h0000_0000;
    end else if (!wdog_fire) begin
      wdog_cnt_q <= wdog_cnt_q + 32'h0000_0001;
    end
  end
  assign wdog_fire = amp_on_q && wdog_cnt_q == 32'(WDOG_CYC - 1);

  // Decoded position
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tell_position_q <= 32'h0000_0000;
    end else if (step_up) begin
      tell_position_q <= tell_position_q + 32'h0000_0001;
    end else if (step_dn) begin
      tell_position_q <= tell_position_q - 32'h0000_0001;
    end
  end

  // Profiler: fixed-rate ramp to target; no accel shaping
  assign diff = target_q - cmd_pos_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      target_q  <= 32'h0000_0000;
      cmd_pos_q <= 32'h0000_0000;
      moving_q  <= 1'b0;
    end else if (begin_motion) begin
      target_q <= cmd_pos_q + relative_distance_q;
      moving_q <= 1'b1;
    end else if (servo_tick && moving_q) begin
      if (diff == 32'h0000_0000) begin
        moving_q <= 1'b0;
      end else if (!diff[31] && diff > 32'(STEP_COUNT)) begin
        cmd_pos_q <= cmd_pos_q + 32'(STEP_COUNT);
      end else if (diff[31] && (32'h0000_0000 - diff) > 32'(STEP_COUNT)) begin
        cmd_pos_q <= cmd_pos_q - 32'(STEP_COUNT);
      end else begin
        cmd_pos_q <= target_q;
      end
    end
  end

  // Position error, zero for a stepper axis
  assign err_d    = stepper ? 32'h0000_0000
                            : cmd_pos_q - tell_position_q;
  assign err_abs  = err_d[31] ? 32'h0000_0000 - err_d : err_d;
  assign err_trip = servo_tick && ctrl_q[CTL_OFF_ON_ERR]
                    && err_abs >= error_limit_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      err_q <= 32'h0000_0000;
    end else if (servo_tick) begin
      err_q <= err_d;
    end
  end

  // Amplifier enable state; any drop cause beats a motor-on write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      amp_on_q <= 1'b0;
    end else if (wdog_fire || motor_off_cmd || err_trip) begin
      amp_on_q <= 1'b0;
    end else if (motor_on_cmd) begin
      amp_on_q <= 1'b1;
    end
  end

  // Proportional drive, polarity set by motor type, then clamped
  assign drive     = ctrl_q[CTL_MTYPE_INV] ? 32'h0000_0000 - err_q
                                           : err_q;
  assign clamp_pos = {16'h0000, torque_clamp_q};
  assign clamp_neg = 32'h0000_0000 - clamp_pos;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      amp_enable_out       <= 1'b0;
      analog_motor_command <= 16'h0000;
    end else begin
      amp_enable_out <= amp_on_q ^ ctrl_q[CTL_AEN_LOW];
      if (!amp_on_q || stepper) begin
        analog_motor_command <= 16'h0000;
      end else if ($signed(drive) > $signed(clamp_pos)) begin
        analog_motor_command <= clamp_pos[15:0];
      end else if ($signed(drive) < $signed(clamp_neg)) begin
        analog_motor_command <= clamp_neg[15:0];
      end else begin
        analog_motor_command <= drive[15:0];
      end
    end
  end

  // Sticky status, a new event wins over the clear; a read clears only
  // the bits it reported, so an event in the setup cycle is not lost
  assign events = {moving_q & servo_tick & diff == 32'h0000_0000,
                   index_seen, err_trip & amp_on_q,
                   motor_off_cmd, wdog_fire};
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_q <= '0;
      irq      <= 1'b0;
    end else begin
      status_q <= ((rd_done && paddr == OFS_STATUS)
                   ? status_q & ~prdata[ST_W-1:0] : status_q) | events;
      irq      <= |(status_q & mask_q);
    end
  end

  sequence s_move_cmd;
    begin_motion;
  endsequence
  sequence s_target_set;
    target_q == $past(cmd_pos_q) + $past(relative_distance_q);
  endsequence

  AST_WDOG_OFF: assert property (@(posedge clk) disable iff (!rstn)
    wdog_fire |=> !amp_on_q ##1 !amp_enable_out == !ctrl_q[CTL_AEN_LOW])
    else $error("watchdog did not drop amplifier enable");

  AST_MOFF: assert property (@(posedge clk) disable iff (!rstn)
    motor_off_cmd |=> !amp_on_q)
    else $error("motor off command ignored");

  AST_AEN_HIGH: assert property (@(posedge clk) disable iff (!rstn)
    !ctrl_q[CTL_AEN_LOW] && $stable(ctrl_q) |=>
      amp_enable_out == $past(amp_on_q))
    else $error("enable output not active high");

  AST_POS_COUNT: assert property (@(posedge clk) disable iff (!rstn)
    step_up && !step_dn |=> tell_position_q == $past(tell_position_q) + 1)
    else $error("count up step lost");

  AST_ERR_TRIP: assert property (@(posedge clk) disable iff (!rstn)
    servo_tick && ctrl_q[CTL_OFF_ON_ERR] && !stepper
      && err_abs >= error_limit_q |=> !amp_on_q [*2])
    else $error("error limit did not disable amplifier");

  AST_CLAMP: assert property (@(posedge clk) disable iff (!rstn)
    $stable(torque_clamp_q) |=>
      $signed({{16{analog_motor_command[15]}}, analog_motor_command})
        <= $signed(clamp_pos)
      && $signed({{16{analog_motor_command[15]}}, analog_motor_command})
        >= $signed(clamp_neg))
    else $error("motor command beyond torque clamp");

  AST_MOVE: assert property (@(posedge clk) disable iff (!rstn)
    s_move_cmd |=> s_target_set)
    else $error("relative target not taken from current position");

  AST_ERR_CALC: assert property (@(posedge clk) disable iff (!rstn)
    servo_tick && !stepper |=>
      err_q == $past(cmd_pos_q) - $past(tell_position_q))
    else $error("position error not commanded minus decoded");

  AST_STEPPER: assert property (@(posedge clk) disable iff (!rstn)
    stepper && servo_tick |=> err_q == 32'h0000_0000
      ##1 analog_motor_command == 16'h0000 || !stepper)
    else $error("stepper axis produced error or drive");
endmodule

// *** common/aes_pkg.sv ***
package aes_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS   = 5;
  localparam int SERVO_PERIOD_US = 1000;
  localparam int SERVO_CYCLES    = SERVO_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int WDOG_PERIOD_MS  = 100;
  localparam int WDOG_CYCLES     =
    WDOG_PERIOD_MS * 1000 * 1000 / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_ERRLIM = 8'h08;
  localparam logic [7:0] OFS_TORQUE = 8'h0C;
  localparam logic [7:0] OFS_RELDST = 8'h10;
  localparam logic [7:0] OFS_TELLPS = 8'h14;
  localparam logic [7:0] OFS_CMDPOS = 8'h18;
  localparam logic [7:0] OFS_POSERR = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_MASK   = 8'h24;

  // Control register fields
  localparam int CTL_OFF_ON_ERR = 0;
  localparam int CTL_MTYPE_INV  = 1;
  localparam int CTL_STEPPER    = 2;
  localparam int CTL_ENC_INV    = 3;
  localparam int CTL_PULSE_DIR  = 4;
  localparam int CTL_AEN_LOW    = 5;
  localparam int CTL_W          = 6;

  // Command register fields (write-only strobes)
  localparam int CMD_MOTOR_OFF = 0;
  localparam int CMD_MOTOR_ON  = 1;
  localparam int CMD_BEGIN     = 2;
  localparam int CMD_WDOG_KICK = 3;

  // Status / mask fields
  localparam int ST_WDOG  = 0;
  localparam int ST_MOFF  = 1;
  localparam int ST_ERROR = 2;
  localparam int ST_INDEX = 3;
  localparam int ST_DONE  = 4;
  localparam int ST_W     = 5;

  // Reset values
  localparam logic [31:0] ERRLIM_RST = 32'h0000_7FFF;
  // 9.99 V of a 10 V, 16-bit signed full scale
  localparam logic [15:0] TORQUE_RST = 16'h7FDE;
  localparam logic [15:0] TORQUE_MAX = 16'h7FFF;
endpackage

// *** rtl/aes_enc_decode.sv ***
`timescale 1ns/100ps
module aes_enc_decode
  import aes_pkg::*;
(
  input  wire logic clk,         // System clock
  input  wire logic rstn,        // Async reset, active low
  input  wire logic a_pin,       // Channel A, asynchronous
  input  wire logic b_pin,       // Channel B, asynchronous
  input  wire logic idx_pin,     // Index channel, asynchronous
  input  wire logic pulse_dir,   // Pulse/direction mode
  input  wire logic dir_inv,     // Invert count direction
  output logic      step_up_q,   // One count up
  output logic      step_dn_q,   // One count down
  output logic      index_q      // Index rising edge
);
  logic [2:0] a_q;
  logic [2:0] b_q;
  logic [2:0] i_q;
  logic       quad_en;
  logic       pd_en;
  logic       cnt_en;
  logic       fwd;

  // Two-stage sync, third stage is history only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      a_q <= 3'h0;
      b_q <= 3'h0;
      i_q <= 3'h0;
    end else begin
      a_q <= {a_q[1:0], a_pin};
      b_q <= {b_q[1:0], b_pin};
      i_q <= {i_q[1:0], idx_pin};
    end
  end

  // Any single edge counts; a double flip is a glitch and is dropped
  assign quad_en = a_q[1] ^ a_q[2] ^ b_q[1] ^ b_q[2];
  // In quadrature, A toggling alone flips direction every edge, so it only dithers
  assign pd_en   = a_q[1] & ~a_q[2];
  assign cnt_en  = pulse_dir ? pd_en : quad_en;
  assign fwd     = (pulse_dir ? b_q[1] : (a_q[1] ^ b_q[2])) ^ dir_inv;

  // Registered count strobes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      step_up_q <= 1'b0;
      step_dn_q <= 1'b0;
      index_q   <= 1'b0;
    end else begin
      step_up_q <= cnt_en & fwd;
      step_dn_q <= cnt_en & ~fwd;
      index_q   <= i_q[1] & ~i_q[2];
    end
  end

  AST_PD_COUNT: assert property (@(posedge clk) disable iff (!rstn)
    pulse_dir && pd_en |=> step_up_q != step_dn_q
      && step_up_q == $past(b_q[1] ^ dir_inv))
    else $error("pulse mode edge not counted with B direction");

  AST_QUAD_EXCL: assert property (@(posedge clk) disable iff (!rstn)
    !pulse_dir && $stable(b_q[2:1]) && $changed(a_q[2:1]) ##1 step_up_q
      |=> ##1 !step_up_q)
    else $error("single channel toggling accumulated counts");
endmodule

// *** sim/aes_motor_model.sv ***
`timescale 1ns/100ps
// Far side of one axis: incremental encoder and a plain amplifier
module aes_motor_model (
  input  wire logic        clk,                  // System clock
  input  wire logic        amp_enable_out,       // Enable from the axis
  input  wire logic [15:0] analog_motor_command, // Drive code
  output logic             enc_chan_a,           // Channel A or pulse
  output logic             enc_chan_b,           // Channel B or direction
  output logic             enc_index             // Index mark
);
  logic [1:0]  ph;
  logic [15:0] drive_v;

  // Amplifier ignores its input while not enabled
  assign drive_v = amp_enable_out ? analog_motor_command : 16'h0000;

  initial begin
    ph         = 2'h0;
    enc_chan_a = 1'b0;
    enc_chan_b = 1'b0;
    enc_index  = 1'b0;
  end

  // Four clocks a state, above the three the decoder needs
  task automatic hold();
    repeat (4) @(posedge clk);
  endtask

  // Quadrature steps, A leading B going forward
  task automatic quad(input logic fwd, input int n, input logic idx);
    logic [1:0] p;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      p = fwd ? ph + 2'h1 : ph - 2'h1;
      ph = p;
      enc_chan_a <= p[1] ^ p[0];
      enc_chan_b <= p[1];
      enc_index  <= idx && (i == 0);
      hold();
    end
    enc_index <= 1'b0;
  endtask

  // Broken channel: A toggles while B stays put
  task automatic dither(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      enc_chan_a <= ~enc_chan_a;
      hold();
    end
  endtask

  // Pulses on A, direction level on B set ahead of each rise
  task automatic pulse(input logic up, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      enc_chan_a <= 1'b0;
      enc_chan_b <= up;
      hold();
      @(posedge clk);
      enc_chan_a <= 1'b1;
      hold();
    end
  endtask
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  import aes_pkg::*;
  localparam int SCYC = 20;
  localparam int WCYC = 200;
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] amc;
  logic        enc_a, enc_b, enc_i, amp_en, irq;
  int          failures = 0;
  int          checks = 0;
  int          seed = 32'hC55C;
  int          pos = 0;
  int          tq, n;
  logic [32:0] exp_q[$];

  aes_axis #(.SERVO_CYC(SCYC), .WDOG_CYC(WCYC), .STEP_COUNT(16))
    aes_axis_inst (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .enc_chan_a(enc_a),
    .enc_chan_b(enc_b), .enc_index(enc_i), .amp_enable_out(amp_en),
    .analog_motor_command(amc), .irq(irq));

  aes_motor_model aes_motor_model_inst (.clk(clk), .amp_enable_out(amp_en),
    .analog_motor_command(amc), .enc_chan_a(enc_a), .enc_chan_b(enc_b),
    .enc_index(enc_i));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  // One APB transfer; reads leave their expectation for the monitor
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [32:0] exp);
    if (!wr)
      exp_q.push_back(exp);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // No wait count assumed; only the hang guard ends a stuck wait
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] exp);
    apb(1'b0, a, 32'h0, exp);
  endtask

  // Read completions compared against the oldest expectation
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      check({pslverr, prdata}, exp_q.pop_front());
  end

  // Hang guard, well beyond the thousand or so cycles the tests need
  initial begin
    #200000;
    failures++;
    complete_run();
  end

  initial begin
    rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0;
    cyc(3);
    rstn <= 1'b1;
    cyc(1);
    // Reset state and register defaults, one unmapped place
    check({32'h0, amp_en}, 33'h0);
    rd(OFS_CTRL, 33'h0);
    rd(OFS_ERRLIM, {1'b0, ERRLIM_RST});
    rd(OFS_TORQUE, {17'h0, TORQUE_RST});
    rd(8'h28, 33'h1_0000_0000);
    // Enable, then off and on together: the drop must win
    wr(OFS_MASK, 32'h2);
    wr(OFS_CMD, 32'hA);
    cyc(3);
    check({32'h0, amp_en}, 33'h1);
    wr(OFS_CMD, 32'h3);
    cyc(3);
    check({32'h0, amp_en}, 33'h0);
    check({32'h0, irq}, 33'h1);
    rd(OFS_STATUS, 33'h2);
    cyc(3);
    check({32'h0, irq}, 33'h0);
    rd(OFS_STATUS, 33'h0);
    // Watchdog: a kick keeps the amplifier on, silence drops it
    wr(OFS_CMD, 32'hA);
    cyc(150);
    wr(OFS_CMD, 32'h8);
    cyc(150);
    check({32'h0, amp_en}, 33'h1);
    cyc(100);
    check({32'h0, amp_en}, 33'h0);
    check({32'h0, irq}, 33'h0);
    rd(OFS_STATUS, 33'h1);
    // Error one short of the limit, then exactly at it
    wr(OFS_ERRLIM, 32'd20);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_CMD, 32'hA);
    wr(OFS_RELDST, 32'd19);
    wr(OFS_CMD, 32'hC);
    cyc(SCYC * 4);
    check({32'h0, amp_en}, 33'h1);
    rd(OFS_CMDPOS, 33'd19);
    rd(OFS_POSERR, 33'd19);
    rd(OFS_STATUS, 33'h10);
    wr(OFS_RELDST, 32'd1);
    wr(OFS_CMD, 32'hC);
    cyc(SCYC * 3);
    check({32'h0, amp_en}, 33'h0);
    rd(OFS_STATUS, 33'h14);
    // Error of 20 held against a random small clamp, both polarities
    tq = 1 + ($random(seed) & 32'hF);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_TORQUE, 32'(tq));
    wr(OFS_CMD, 32'hA);
    cyc(SCYC * 2);
    check({17'h0, amc}, 33'(tq));
    check({17'h0, aes_motor_model_inst.drive_v}, 33'(tq));
    wr(OFS_CTRL, 32'h2);
    cyc(SCYC * 2);
    check({17'h0, amc}, {17'h0, 16'(-tq)});
    wr(OFS_CTRL, 32'h4);
    cyc(SCYC * 2);
    check({17'h0, amc}, 33'h0);
    rd(OFS_POSERR, 33'h0);
    wr(OFS_CMD, 32'h1);
    cyc(3);
    rd(OFS_STATUS, 33'h2);
    // Encoder traffic with the amplifier off
    n = 1 + ($random(seed) & 32'h3);
    wr(OFS_CTRL, 32'h0);
    aes_motor_model_inst.quad(1'b1, n, 1'b1);
    pos += n;
    cyc(8);
    rd(OFS_TELLPS, {1'b0, 32'(pos)});
    rd(OFS_STATUS, 33'h8);
    aes_motor_model_inst.quad(1'b0, n + 2, 1'b0);
    pos -= n + 2;
    cyc(8);
    rd(OFS_TELLPS, {1'b0, 32'(pos)});
    wr(OFS_CTRL, 32'h8);
    aes_motor_model_inst.quad(1'b1, 3, 1'b0);
    pos -= 3;
    cyc(8);
    rd(OFS_TELLPS, {1'b0, 32'(pos)});
    wr(OFS_CTRL, 32'h0);
    aes_motor_model_inst.dither(6);
    cyc(8);
    rd(OFS_TELLPS, {1'b0, 32'(pos)});
    wr(OFS_CTRL, 32'h10);
    aes_motor_model_inst.pulse(1'b1, 3);
    aes_motor_model_inst.pulse(1'b0, 2);
    pos += 1;
    cyc(8);
    rd(OFS_TELLPS, {1'b0, 32'(pos)});
    // Active-low enable option: amplifier off shows as a high pin
    wr(OFS_CTRL, 32'h20);
    cyc(3);
    check({32'h0, amp_en}, 33'h1);
    cyc(4);
    complete_run();
  end
endmodule
